// [logic/adc_ctrl_consts.svh]
// constants for the converter control block: register addresses, field
// positions, reset values and timing counts
// assumes inclusion by bare name from the package and the design module
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
`define ADDR_CONTROL_STATUS 8'hD8
`define ADDR_RESULT 8'hD9
`define ADDR_TRIGGER 8'hDA
`define ADDR_ADVANCED_FUNC 8'hA6
`define BIT_CHAN_LO 0
`define BIT_CHAN_HI 1
`define BIT_RESERVED2 2
`define BIT_REPEAT_MODE 3
`define BIT_ACTIVE 4
`define BIT_DONE_IRQ 5
`define BIT_LONG_SAMPLE 6
`define BIT_CLOCK_HALVER 7
`define BIT_CORE_HALVE 7
`define CONTROL_RESET 8'h00
`define ADVANCED_RESET 8'h00
`define RESULT_RESET 8'h00
`define MASTER_CLKS_PER_STEP 32
`define SAMPLE_SHORT 2
`define SAMPLE_LONG 8
`define BASE_STEPS 4
`define DIV_CNT_W 2
`define PHASE_CNT_W 9
`endif

// [logic/adc_ctrl_pkg.sv]
// types for the converter control block
// assumes the constants header is on the include path
`include "adc_ctrl_consts.svh"
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;
endpackage

// [logic/adc_conversion_control.sv]
// converter control: special function register slave, clock prescaling,
// sample and successive approximation sequencer for an 8-bit converter
// assumes a synchronous cpu register port and an analog comparator input
// from the capacitor-array core; clk_sys_in is the oscillator clock
//
// Function
// - conversion lasts (2^(2*long)+4)*32*2^core*2^halver oscillator periods
// - repeat bit clear: one conversion per start, then stop
// - repeat bit set: next conversion starts right after previous finishes
// - busy flag bit 4 set while converting, cleared by hardware on completion with repeat bit clear
// - busy flag is read-only; writes do not change it
// - two channel bits choose which of four analog inputs is converted
// - halver bit set divides chip clock by two for converter master clock
// - sample phase lasts 32 master clocks, or 128 with long-sample bit set
// - result register keeps last value until next conversion or a software write overwrites it
// - result register is readable and writable by software
// - a write to trigger address while idle starts conversion; no storage bits
// - reads of trigger address return arbitrary values
// - control register supports single-bit set and clear besides byte writes
// - done flag set on completion, never cleared by hardware; software clears
// - channel bits decode as binary channel number 0 to 3
// - core halve bit set runs chip clock at half the oscillator rate
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"
module adc_conversion_control (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  input wire logic sfr_bit_wr_in,
  input wire logic [2:0] sfr_bit_sel_in,
  input wire logic sfr_bit_val_in,
  input wire logic sfr_rd_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic comparator_in,
  output logic [1:0] channel_sel_out,
  output logic sample_out,
  output logic [7:0] dac_code_out,
  output logic conversion_done_irq_out
);
  // control register fields and state
  logic [7:0] converter_control_status;
  logic [7:0] next_control;
  logic [7:0] advanced_function_reg;
  logic [7:0] next_advanced;
  logic [7:0] conversion_result;
  logic [7:0] next_result;
  adc_ctrl_pkg::conv_state_t state;
  adc_ctrl_pkg::conv_state_t next_state;
  logic [`DIV_CNT_W-1:0] div_cnt;
  logic [`DIV_CNT_W-1:0] next_div_cnt;
  logic [`PHASE_CNT_W-1:0] phase_cnt;
  logic [`PHASE_CNT_W-1:0] next_phase_cnt;
  logic [7:0] sar;
  logic [7:0] next_sar;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic [1:0] chan_latched;
  logic [1:0] next_chan;
  logic master_tick;
  logic start_req;
  logic done_evt;
  logic ctl_wr;
  logic [7:0] ctl_wdata;
  logic repeat_mode_select;
  logic long_sample_select;
  logic clock_halver;
  logic core_clock_halve;
  logic start_go;
  logic step_now;
  logic phase_end;
  logic res_wr;
  logic adv_wr;

  assign repeat_mode_select = converter_control_status[`BIT_REPEAT_MODE];
  assign long_sample_select = converter_control_status[`BIT_LONG_SAMPLE];
  assign clock_halver = converter_control_status[`BIT_CLOCK_HALVER];
  assign core_clock_halve = advanced_function_reg[`BIT_CORE_HALVE];

  // one-cycle count of a phase length in master clocks
  function automatic logic [`PHASE_CNT_W-1:0] phase_len(input logic sampling,
                                                        input logic long_s);
    logic [`PHASE_CNT_W-1:0] len;
    len = '0;
    if (sampling) begin
      // sample: 1 or 4 steps of 32 master clocks, 4 steps = (2^2)*1
      len = long_s ? `PHASE_CNT_W'(`SAMPLE_LONG * `MASTER_CLKS_PER_STEP / 2)
                   : `PHASE_CNT_W'(`SAMPLE_SHORT * `MASTER_CLKS_PER_STEP / 2);
    end else begin
      len = `PHASE_CNT_W'(`BASE_STEPS * `MASTER_CLKS_PER_STEP);
    end
    phase_len = len - `PHASE_CNT_W'(1);
  endfunction

  // true when a strobe targets the given register address
  function automatic logic addr_hit(input logic strobe, input logic [7:0] addr,
                                    input logic [7:0] target);
    addr_hit = strobe && (addr == target);
  endfunction

  // channel number held in the two low control bits
  function automatic logic [1:0] chan_field(input logic [7:0] ctl);
    chan_field = ctl[`BIT_CHAN_HI:`BIT_CHAN_LO];
  endfunction

  // master clock enable: oscillator divided by 2^core * 2^halver; the divider
  // restarts on an accepted trigger so every conversion has the exact length
  always_comb begin
    next_div_cnt = div_cnt + `DIV_CNT_W'(1);
    if (start_go) begin
      next_div_cnt = '0;
    end
    master_tick = 1'b0;
    case ({core_clock_halve, clock_halver})
      2'b00: master_tick = 1'b1;
      2'b01, 2'b10: master_tick = div_cnt[0];
      2'b11: master_tick = (div_cnt == 2'b11);
      default: master_tick = 1'b0;
    endcase
  end

  // divider register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // register access decode; a byte write wins over a bit write
  always_comb begin
    start_req = addr_hit(sfr_wr_in, sfr_addr_in, `ADDR_TRIGGER);
    start_go = start_req && (state == adc_ctrl_pkg::ST_IDLE); // busy ignores triggers
    adv_wr = addr_hit(sfr_wr_in, sfr_addr_in, `ADDR_ADVANCED_FUNC);
    res_wr = addr_hit(sfr_wr_in, sfr_addr_in, `ADDR_RESULT);
    ctl_wr = 1'b0;
    ctl_wdata = converter_control_status;
    if (addr_hit(sfr_wr_in, sfr_addr_in, `ADDR_CONTROL_STATUS)) begin
      ctl_wr = 1'b1;
      ctl_wdata = sfr_wdata_in;
    end else if (addr_hit(sfr_bit_wr_in, sfr_addr_in, `ADDR_CONTROL_STATUS)) begin
      ctl_wr = 1'b1;
      ctl_wdata[sfr_bit_sel_in] = sfr_bit_val_in;
    end
  end

  // sequencer: sample phase, then eight approximation steps over 4 units
  always_comb begin
    next_state = state;
    next_phase_cnt = phase_cnt;
    next_sar = sar;
    next_bit_idx = bit_idx;
    next_chan = chan_latched;
    done_evt = 1'b0;
    step_now = master_tick && (phase_cnt[3:0] == 4'h0); // one decision per 16 ticks
    phase_end = master_tick && (phase_cnt == '0);
    case (state)
      adc_ctrl_pkg::ST_IDLE: begin
        if (start_go) begin
          next_state = adc_ctrl_pkg::ST_SAMPLE;
          next_chan = chan_field(converter_control_status);
          next_phase_cnt = phase_len(1'b1, long_sample_select);
        end
      end
      adc_ctrl_pkg::ST_SAMPLE: begin
        if (phase_end) begin
          next_state = adc_ctrl_pkg::ST_CONVERT;
          next_phase_cnt = phase_len(1'b0, long_sample_select);
          next_sar = 8'h80;
          next_bit_idx = 3'h7;
        end else if (master_tick) begin
          next_phase_cnt = phase_cnt - `PHASE_CNT_W'(1);
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        // comparator settles the trial bit, the next lower bit becomes the trial
        if (step_now) begin
          next_sar[bit_idx] = comparator_in;
          if (bit_idx != 3'h0) begin
            next_sar[bit_idx - 3'h1] = 1'b1;
            next_bit_idx = bit_idx - 3'h1;
          end
        end
        if (phase_end) begin
          done_evt = 1'b1;
          if (repeat_mode_select) begin
            next_state = adc_ctrl_pkg::ST_SAMPLE;
            next_chan = chan_field(converter_control_status);
            next_phase_cnt = phase_len(1'b1, long_sample_select);
          end else begin
            next_state = adc_ctrl_pkg::ST_IDLE;
          end
        end else if (master_tick) begin
          next_phase_cnt = phase_cnt - `PHASE_CNT_W'(1);
        end
      end
      default: next_state = adc_ctrl_pkg::ST_IDLE;
    endcase
  end

  // control register next value; the busy bit always mirrors the sequencer
  always_comb begin
    next_control = ctl_wr ? ctl_wdata : converter_control_status;
    next_control[`BIT_ACTIVE] = (next_state != adc_ctrl_pkg::ST_IDLE);
    if (done_evt) begin
      next_control[`BIT_DONE_IRQ] = 1'b1;
    end
  end

  // control register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      converter_control_status <= `CONTROL_RESET;
    end else begin
      converter_control_status <= next_control;
    end
  end

  // advanced function next value: only the core halve bit is kept
  always_comb begin
    next_advanced = advanced_function_reg;
    if (adv_wr) begin
      next_advanced = {sfr_wdata_in[`BIT_CORE_HALVE], 7'h00};
    end
  end

  // advanced function register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      advanced_function_reg <= `ADVANCED_RESET;
    end else begin
      advanced_function_reg <= next_advanced;
    end
  end

  // result next value; completion wins over a software write
  always_comb begin
    next_result = conversion_result;
    if (res_wr) begin
      next_result = sfr_wdata_in;
    end
    if (done_evt) begin
      next_result = next_sar;
    end
  end

  // result register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      conversion_result <= `RESULT_RESET;
    end else begin
      conversion_result <= next_result;
    end
  end

  // read data next value; zero whenever no read is strobed
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_rd_in) begin
      case (sfr_addr_in)
        `ADDR_CONTROL_STATUS: next_rdata = converter_control_status;
        `ADDR_RESULT: next_rdata = conversion_result;
        `ADDR_ADVANCED_FUNC: next_rdata = advanced_function_reg;
        `ADDR_TRIGGER: next_rdata = sar;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  // read data register
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // sequencer registers
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= adc_ctrl_pkg::ST_IDLE;
      phase_cnt <= '0;
      sar <= 8'h00;
      bit_idx <= 3'h0;
      chan_latched <= 2'b00;
    end else begin
      state <= next_state;
      phase_cnt <= next_phase_cnt;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      chan_latched <= next_chan;
    end
  end

  // outputs toward the cpu and the analog core
  assign sfr_rdata_out = rdata;
  assign channel_sel_out = chan_latched;
  assign sample_out = (state == adc_ctrl_pkg::ST_SAMPLE);
  assign dac_code_out = sar;
  assign conversion_done_irq_out = converter_control_status[`BIT_DONE_IRQ];
endmodule

// [test/adc_conversion_control_chk.sv]
// checker: port timing of the converter control block
// assumes it is bound to the converter control module
`timescale 1ns/1ps
module adc_conversion_control_chk (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic sfr_bit_wr_in,
  input wire logic [2:0] sfr_bit_sel_in,
  input wire logic sfr_rd_in,
  input wire logic [7:0] sfr_rdata_out,
  input wire logic [1:0] channel_sel_out,
  input wire logic sample_out,
  input wire logic conversion_done_irq_out
);
  logic [9:0] scnt;
  logic [9:0] next_scnt;
  // length of the running sample phase
  always_comb next_scnt = sample_out ? scnt + 10'h001 : 10'h000;
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in)
      scnt <= 10'h000;
    else
      scnt <= next_scnt;
  end
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  a_rdata_idle_zero: assert property (!sfr_rd_in |=> sfr_rdata_out == 8'h00)
    else $error("read data not zero without read");
  a_done_flag_sticky: assert property (conversion_done_irq_out &&
    !(sfr_wr_in && sfr_addr_in == 8'hD8) && !(sfr_bit_wr_in && sfr_addr_in == 8'hD8 &&
    sfr_bit_sel_in == 3'h5) |=> conversion_done_irq_out) else $error("done flag dropped");
  a_sample_phase_len: assert property ($fell(sample_out) |->
    scnt inside {10'h020, 10'h040, 10'h080, 10'h100, 10'h200}) else $error("bad sample length");
  a_channel_held: assert property (sample_out && !$rose(sample_out) |->
    $stable(channel_sel_out)) else $error("channel moved while sampling");
  a_busy_read_back: assert property (sfr_rd_in && sfr_addr_in == 8'hD8 && sample_out
    |=> sfr_rdata_out[4]) else $error("busy bit low while sampling");
  a_trigger_starts: assert property (sfr_rd_in && sfr_addr_in == 8'hD8 ##1
    !sfr_rdata_out[4] ##1 sfr_wr_in && sfr_addr_in == 8'hDA |=> sample_out)
    else $error("trigger did not start sampling");
  a_done_after_convert: assert property ($rose(conversion_done_irq_out) &&
    !$past(sfr_wr_in) && !$past(sfr_bit_wr_in) |-> !$past(sample_out))
    else $error("done flag set outside conversion end");
  a_done_read_back: assert property (sfr_rd_in && sfr_addr_in == 8'hD8 |=>
    sfr_rdata_out[5] == $past(conversion_done_irq_out)) else $error("done bit read wrong");
  c_done: cover property ($rose(conversion_done_irq_out));
  c_longest: cover property ($fell(sample_out) && scnt == 10'h200);
  c_trigger: cover property (sfr_wr_in && sfr_addr_in == 8'hDA);
endmodule
bind adc_conversion_control adc_conversion_control_chk chk (.clk_sys_in(clk_sys_in),
  .sys_rst_in(sys_rst_in), .sfr_addr_in(sfr_addr_in), .sfr_wr_in(sfr_wr_in),
  .sfr_bit_wr_in(sfr_bit_wr_in), .sfr_bit_sel_in(sfr_bit_sel_in), .sfr_rd_in(sfr_rd_in),
  .sfr_rdata_out(sfr_rdata_out), .channel_sel_out(channel_sel_out),
  .sample_out(sample_out), .conversion_done_irq_out(conversion_done_irq_out));

// [test/adc_analog_model.sv]
// model: four analog inputs and the comparator of the capacitor array
// assumes the bench sets one 8-bit level per channel
`timescale 1ns/1ps
module adc_analog_model (
  input wire logic [1:0] channel_sel_in,
  input wire logic [7:0] dac_code_in,
  input wire logic [31:0] levels_in,
  output logic comparator_out
);
  // keep the trial bit while the selected level reaches the trial code
  assign comparator_out = levels_in[channel_sel_in*8 +: 8] >= dac_code_in;
endmodule

// [test/adc_conversion_control_tb.sv]
// testbench: register-level tests of the converter control block
// assumes the analog model and the bound checker are compiled first
`timescale 1ns/1ps
module adc_conversion_control_tb;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic bwr = 1'b0;
  logic [2:0] bsel = 3'h0;
  logic bval = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata, dac;
  logic [1:0] chan;
  logic cmp, samp, done;
  logic [31:0] levels = 32'hC3_5A_0F_81;
  logic [7:0] cfg;
  int n_fail = 0;
  int total_checks = 0;
  int n;
  int t_exp;
  // clock and parts
  always #20 clk_sys_in = ~clk_sys_in;
  adc_conversion_control dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_bit_wr_in(bwr),
    .sfr_bit_sel_in(bsel), .sfr_bit_val_in(bval), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
    .comparator_in(cmp), .channel_sel_out(chan), .sample_out(samp), .dac_code_out(dac),
    .conversion_done_irq_out(done));
  adc_analog_model core (.channel_sel_in(chan), .dac_code_in(dac), .levels_in(levels),
    .comparator_out(cmp));
  // compare helpers and register access
  task automatic chk8(input string s, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic chk_n(input string s, input int e, input int g);
    total_checks++;
    if (g != e) begin
      n_fail++;
      $display("MISMATCH %s expected %0d seen %0d", s, e, g);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_in);
    wr <= 1'b0;
  endtask
  task automatic bitw(input logic [2:0] s, input logic v);
    @(posedge clk_sys_in);
    addr <= 8'hD8;
    bsel <= s;
    bval <= v;
    bwr <= 1'b1;
    @(posedge clk_sys_in);
    bwr <= 1'b0;
  endtask
  task automatic rchk(input string s, input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_in);
    rd <= 1'b0;
    #1 chk8(s, e, rdata);
  endtask
  task automatic wait_done;
    n = 0;
    #1; // let a flag clear made at this edge settle
    while (done !== 1'b1 && n < 2000) begin
      @(posedge clk_sys_in);
      n++;
      #1;
    end
    if (n >= 2000) begin
      n_fail++;
      $display("MISMATCH done_wait expected done seen timeout");
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // watchdog against a hung conversion
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    n_fail++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    rchk("ctl_rst", 8'hD8, 8'h00);
    rchk("unmapped", 8'h00, 8'h00);
    wreg(8'hD9, 8'h5A);
    rchk("result_rw", 8'hD9, 8'h5A);
    wreg(8'hD8, 8'h10);
    rchk("busy_ro", 8'hD8, 8'h00);
    for (int i = 0; i < 4; i++) begin
      cfg = {i[1], i[0], 4'h0, i[1], i[0]};
      wreg(8'hA6, {i[0], 7'h00});
      rchk("adv", 8'hA6, {i[0], 7'h00});
      wreg(8'hD8, cfg);
      rchk("ctl_cfg", 8'hD8, cfg);
      wreg(8'hDA, 8'h00);
      wait_done();
      t_exp = ((1 << (2 * i[0])) + 4) * 32 * (1 << i[0]) * (1 << i[1]);
      chk_n("conv_time", t_exp, n);
      chk8("chan", {6'h00, i[1:0]}, {6'h00, chan});
      chk8("dac", levels[i*8 +: 8], dac);
      rchk("result", 8'hD9, levels[i*8 +: 8]);
      rchk("ctl_done", 8'hD8, cfg | 8'h20);
      bitw(3'h5, 1'b0);
      rchk("ctl_clr", 8'hD8, cfg);
    end
    wreg(8'hA6, 8'h00);
    wreg(8'hD8, 8'h00);
    bitw(3'h3, 1'b1);
    rchk("rep_set", 8'hD8, 8'h08);
    wreg(8'hDA, 8'h00);
    rchk("busy", 8'hD8, 8'h18);
    wait_done();
    rchk("rep_res1", 8'hD9, 8'h81);
    @(posedge clk_sys_in);
    levels[7:0] <= 8'h3C;
    bitw(3'h5, 1'b0);
    wait_done();
    rchk("rep_res2", 8'hD9, 8'h3C);
    bitw(3'h3, 1'b0);
    bitw(3'h5, 1'b0);
    wait_done();
    repeat (400) @(posedge clk_sys_in);
    rchk("rep_stop", 8'hD8, 8'h20);
    bitw(3'h5, 1'b0);
    repeat (400) @(posedge clk_sys_in);
    rchk("idle", 8'hD8, 8'h00);
    finish_test();
  end
endmodule
